//--- rtl/cls_cfg.svh
// Constants for the reference loss, skip and lock supervisor
`ifndef CLS_CFG_SVH
`define CLS_CFG_SVH

// ==========================================================
// Timing
`define CLS_CLK_FREQ_KHZ 125000
`define CLS_SKIP_WINDOW_MS 20
`define CLS_SKIP_CYCLES (`CLS_SKIP_WINDOW_MS * `CLS_CLK_FREQ_KHZ)
`define CLS_LOSS_CYCLES 24'h800000
`define CLS_LOCK_PERIODS 8'h64
`define CLS_CNT_W 24

// ==========================================================
// Register byte offsets
`define CLS_OFS_CTRL 8'h00
`define CLS_OFS_RATIO 8'h04
`define CLS_OFS_STATUS 8'h08
`define CLS_OFS_IRQ_STAT 8'h0c
`define CLS_OFS_IRQ_MASK 8'h10
`define CLS_OFS_DIVIDE 8'h14

// ==========================================================
// Control fields
`define CLS_CTRL_DIV_LSB 0
`define CLS_CTRL_SKIP_BIT 2
`define CLS_CTRL_UNL_BIT 3
`define CLS_CTRL_BW_LSB 4
`define CLS_CTRL_RESET 32'h00000000
`define CLS_RATIO_RESET 32'h00000100

// ==========================================================
// Interrupt bits
`define CLS_IRQ_LOCK 0
`define CLS_IRQ_UNLOCK 1
`define CLS_IRQ_TIMEOUT 2
`define CLS_IRQ_FREQ 3
`define CLS_IRQ_W 4

// ==========================================================
// Loop filter shift: narrowest band at select 0
`define CLS_SHIFT_BASE 4'h8

// ==========================================================
// Bus answers
`define CLS_RESP_OKAY 2'b00
`define CLS_RESP_SLVERR 2'b10

`endif

//--- rtl/cls_pkg.sv
// Types for the reference loss, skip and lock supervisor
package cls_pkg;
	// Supervisor states
	typedef enum logic [1:0] {
		ST_ACQ,
		ST_LOCK,
		ST_GAP,
		ST_LOST
	} cls_state_t;
	// Register word
	typedef logic [31:0] cls_word_t;
endpackage

//--- rtl/cls_sync.sv
// Two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module cls_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg; // First stage, read only by second
	logic [W-1:0] sync_reg; // Second stage

	// Two stages, constant reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule

//--- rtl/cls_ctrl.sv
// Reference loss, skip and lock supervisor with AXI4-Lite registers
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cls_cfg.svh"
module cls_ctrl #(
	parameter logic [23:0] SKIP_CYCLES = 24'(`CLS_SKIP_CYCLES),
	parameter logic [23:0] LOSS_CYCLES = `CLS_LOSS_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic reference_input_pin,
	input wire logic feedback_pin,
	output logic [1:0] ref_divider_sel,
	output cls_pkg::cls_word_t synth_divide,
	output logic pll_out_enable,
	output logic lock_status,
	output logic loop_bw_wide,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import cls_pkg::*;

	// ==========================================================
	// Pin synchronisers and edge detect
	logic [1:0] pins_sync; // Synchronised reference and feedback
	logic ref_d_reg; // Previous reference level
	logic fb_d_reg; // Previous feedback level
	logic ref_edge; // Rising reference edge
	logic fb_edge; // Rising feedback edge

	cls_sync #(.W(2)) u_sync (
		.clock(clock),
		.rst(rst),
		.d({feedback_pin, reference_input_pin}),
		.q(pins_sync)
	);

	// Edge history
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_d_reg <= 1'b0;
			fb_d_reg <= 1'b0;
		end else begin
			ref_d_reg <= pins_sync[0];
			fb_d_reg <= pins_sync[1];
		end
	end

	assign ref_edge = pins_sync[0] & ~ref_d_reg;
	assign fb_edge = pins_sync[1] & ~fb_d_reg;

	// ==========================================================
	// Configuration registers
	cls_word_t ctrl_reg; // Divider, skip, unlock policy, bandwidth
	cls_word_t ratio_reg; // Output edges wanted per reference period
	logic [3:0] irq_stat_reg; // Sticky events
	logic [3:0] irq_mask_reg; // Enables
	logic skip_en; // Skip tolerance enable
	logic unl_en; // Output on unlock enable
	logic [2:0] bw_sel; // Minimum loop bandwidth select

	assign ref_divider_sel = ctrl_reg[`CLS_CTRL_DIV_LSB +: 2];
	assign skip_en = ctrl_reg[`CLS_CTRL_SKIP_BIT];
	assign unl_en = ctrl_reg[`CLS_CTRL_UNL_BIT];
	assign bw_sel = ctrl_reg[`CLS_CTRL_BW_LSB +: 3];

	// ==========================================================
	// Reference interval measurement
	cls_state_t state_reg; // Supervisor state
	cls_state_t state_next;
	logic [23:0] since_reg; // Cycles since last reference edge
	logic [23:0] per_reg; // Last measured period
	logic per_ok_reg; // Period holds a valid measurement
	logic [23:0] diff; // Distance of interval from period
	logic [23:0] tol; // Allowed period deviation
	logic freq_chg; // Interval departs from period
	logic late; // Interval overruns period: pulses missing
	logic lost; // Loss timeout reached
	logic short_gap; // Gap ended inside skip window

	assign diff = (since_reg > per_reg) ? since_reg - per_reg :
		per_reg - since_reg;
	assign tol = {3'h0, per_reg[23:3]};
	assign freq_chg = ref_edge & per_ok_reg & (diff > tol);
	assign late = per_ok_reg & (since_reg > per_reg + tol + tol);
	assign lost = since_reg >= LOSS_CYCLES;
	assign short_gap = since_reg < SKIP_CYCLES;

	// Interval counter, saturating at the loss timeout
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			since_reg <= 24'h000000;
		end else if (ref_edge) begin
			since_reg <= 24'h000001;
		end else if (!lost) begin
			since_reg <= since_reg + 24'h000001;
		end
	end

	// Period capture; a gap or loss spoils the measurement
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			per_reg <= 24'h000000;
			per_ok_reg <= 1'b0;
		end else if (ref_edge) begin
			per_reg <= since_reg;
			per_ok_reg <= (state_reg == ST_ACQ) ||
				(state_reg == ST_LOCK);
		end
	end

	// ==========================================================
	// Supervisor state machine
	logic lock_reg; // Lock status flag
	logic lock_next;
	logic hold_reg; // Output held on through skip reacquisition
	logic hold_next;
	logic [7:0] stable_reg; // Consistent periods while acquiring
	logic [7:0] stable_next;
	logic [3:0] ev; // Events this cycle

	// Next state, lock flag and events
	always_comb begin
		state_next = state_reg;
		lock_next = lock_reg;
		hold_next = hold_reg;
		stable_next = stable_reg;
		ev = 4'h0;
		case (state_reg)
			ST_ACQ: begin
				// Count steady periods until the lock time has passed
				if (lost) begin
					state_next = ST_LOST;
					lock_next = 1'b0;
					hold_next = 1'b0;
					ev[`CLS_IRQ_TIMEOUT] = 1'b1;
					ev[`CLS_IRQ_UNLOCK] = lock_reg;
				end else if (freq_chg) begin
					stable_next = 8'h00;
				end else if (ref_edge && per_ok_reg) begin
					stable_next = stable_reg + 8'h01;
					if (stable_next >= `CLS_LOCK_PERIODS) begin
						state_next = ST_LOCK;
						lock_next = 1'b1;
						hold_next = 1'b0;
						ev[`CLS_IRQ_LOCK] = ~lock_reg;
					end
				end
			end
			ST_LOCK: begin
				// Edge off the period by more than the tolerance, early or late: unlock at once
				if (freq_chg) begin
					state_next = ST_ACQ;
					lock_next = 1'b0;
					stable_next = 8'h00;
					ev[`CLS_IRQ_FREQ] = 1'b1;
					ev[`CLS_IRQ_UNLOCK] = 1'b1;
				end else if (late) begin
					state_next = ST_GAP;
				end
			end
			ST_GAP: begin
				// Output keeps running while pulses are missing
				if (lost) begin
					state_next = ST_LOST;
					lock_next = 1'b0;
					ev[`CLS_IRQ_TIMEOUT] = 1'b1;
					ev[`CLS_IRQ_UNLOCK] = 1'b1;
				end else if (ref_edge) begin
					state_next = ST_ACQ;
					stable_next = 8'h00;
					if (short_gap && skip_en) begin
						hold_next = 1'b1;
					end else begin
						lock_next = 1'b0;
						ev[`CLS_IRQ_UNLOCK] = 1'b1;
					end
				end
			end
			ST_LOST: begin
				// Returning reference starts a fresh acquisition
				if (ref_edge) begin
					state_next = ST_ACQ;
					stable_next = 8'h00;
				end
			end
			default: begin
				state_next = ST_ACQ;
				lock_next = 1'b0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= ST_ACQ;
			lock_reg <= 1'b0;
			hold_reg <= 1'b0;
			stable_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			lock_reg <= lock_next;
			hold_reg <= hold_next;
			stable_reg <= stable_next;
		end
	end

	// ==========================================================
	// Output gating
	logic out_en_reg; // Synthesized output enable
	logic out_en_next;

	assign out_en_next = lock_next | hold_next | unl_en |
		(state_next == ST_GAP);

	// Output enable flop
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_en_reg <= 1'b0;
		end else begin
			out_en_reg <= out_en_next;
		end
	end

	assign pll_out_enable = out_en_reg;
	assign lock_status = lock_reg;

	// ==========================================================
	// Digital loop: feedback count per reference period
	logic [31:0] fb_cnt_reg; // Feedback edges this period
	cls_word_t div_reg; // Synthesizer divide value
	logic wide; // Acquisition forces wide band unless skip hold is on
	logic [3:0] shift; // Loop gain shift
	logic signed [32:0] err; // Ratio error
	logic signed [32:0] step; // Filtered correction
	logic loop_upd; // Apply correction this cycle

	assign wide = (state_reg == ST_ACQ) & ~hold_reg;
	assign shift = wide ? 4'h0 :
		`CLS_SHIFT_BASE - {1'b0, bw_sel};
	assign err = $signed({1'b0, ratio_reg}) -
		$signed({1'b0, fb_cnt_reg});
	assign step = err >>> shift;
	assign loop_upd = ref_edge & per_ok_reg & ~freq_chg &
		((state_reg == ST_ACQ) || (state_reg == ST_LOCK));

	// Count output edges between reference edges
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fb_cnt_reg <= 32'h00000000;
		end else if (ref_edge) begin
			fb_cnt_reg <= {31'h0, fb_edge};
		end else if (fb_edge) begin
			fb_cnt_reg <= fb_cnt_reg + 32'h00000001;
		end
	end

	// Integrate correction into the divide value; held in gaps
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_reg <= `CLS_RATIO_RESET;
		end else if (loop_upd) begin
			div_reg <= div_reg + step[31:0];
		end
	end

	assign synth_divide = div_reg;
	assign loop_bw_wide = wide;

	// ==========================================================
	// AXI4-Lite write path
	logic aw_hold_reg; // Write address held
	logic [7:0] awaddr_reg;
	logic w_hold_reg; // Write data held
	cls_word_t wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic do_wr; // Both halves present
	logic wr_ok; // Address decodes
	cls_word_t wmask; // Byte lane mask
	logic [3:0] w1c; // Interrupt bits cleared

	assign s_axi_awready = ~aw_hold_reg;
	assign s_axi_wready = ~w_hold_reg;
	assign do_wr = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign wr_ok = (awaddr_reg == `CLS_OFS_CTRL) ||
		(awaddr_reg == `CLS_OFS_RATIO) ||
		(awaddr_reg == `CLS_OFS_IRQ_STAT) ||
		(awaddr_reg == `CLS_OFS_IRQ_MASK);
	assign w1c = (do_wr && awaddr_reg == `CLS_OFS_IRQ_STAT) ?
		(wdata_reg[3:0] & wmask[3:0]) : 4'h0;

	// Capture address and data in either order, then answer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			w_hold_reg <= 1'b0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `CLS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_hold_reg) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_hold_reg) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? `CLS_RESP_OKAY : `CLS_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Register writes with byte lanes; new events beat the clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `CLS_CTRL_RESET;
			ratio_reg <= `CLS_RATIO_RESET;
			irq_mask_reg <= 4'h0;
			irq_stat_reg <= 4'h0;
		end else begin
			if (do_wr && awaddr_reg == `CLS_OFS_CTRL) begin
				ctrl_reg <= ((ctrl_reg & ~wmask) | (wdata_reg & wmask)) &
					32'h0000007f;
			end
			if (do_wr && awaddr_reg == `CLS_OFS_RATIO) begin
				ratio_reg <= (ratio_reg & ~wmask) | (wdata_reg & wmask);
			end
			if (do_wr && awaddr_reg == `CLS_OFS_IRQ_MASK) begin
				irq_mask_reg <= (irq_mask_reg & ~wmask[3:0]) |
					(wdata_reg[3:0] & wmask[3:0]);
			end
			irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ==========================================================
	// AXI4-Lite read path
	logic rvalid_reg;
	cls_word_t rdata_reg;
	logic [1:0] rresp_reg;
	logic [7:0] raddr; // Word-aligned read address
	cls_word_t rmux; // Selected read word
	logic rd_ok; // Address decodes
	cls_word_t status_word; // Live state

	assign s_axi_arready = ~rvalid_reg;
	assign raddr = {s_axi_araddr[7:2], 2'b00};
	assign status_word = {26'h0, state_reg, loop_bw_wide, hold_reg,
		out_en_reg, lock_reg};
	assign rd_ok = (raddr <= `CLS_OFS_DIVIDE);
	assign rmux = (raddr == `CLS_OFS_CTRL) ? ctrl_reg :
		(raddr == `CLS_OFS_RATIO) ? ratio_reg :
		(raddr == `CLS_OFS_STATUS) ? status_word :
		(raddr == `CLS_OFS_IRQ_STAT) ? {28'h0, irq_stat_reg} :
		(raddr == `CLS_OFS_IRQ_MASK) ? {28'h0, irq_mask_reg} :
		(raddr == `CLS_OFS_DIVIDE) ? div_reg : 32'h00000000;

	// Take a read address and hold the answer until taken
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `CLS_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rmux;
			rresp_reg <= rd_ok ? `CLS_RESP_OKAY : `CLS_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
endmodule

//--- tb/cls_ctrl_properties.sv
// Port-level checks for the reference loss and lock supervisor
`timescale 1ns/1ps
module cls_ctrl_properties #(
	parameter logic [23:0] SKIP_CYCLES = 24'd200,
	parameter logic [23:0] LOSS_CYCLES = 24'd2000
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic reference_input_pin,
	input wire logic pll_out_enable,
	input wire logic lock_status,
	input wire logic loop_bw_wide,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========================================
	// Idle cycles since the last raw reference rise
	logic [23:0] idle_reg; // Saturates at all ones
	logic ref_reg; // Pin one cycle back
	wire logic ref_rise = reference_input_pin && !ref_reg;
	wire logic idle_full = &idle_reg;
	// Count restarts on every rise
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			idle_reg <= 24'h0;
			ref_reg <= 1'b0;
		end else begin
			ref_reg <= reference_input_pin;
			if (ref_rise) idle_reg <= 24'h0;
			else if (!idle_full) idle_reg <= idle_reg + 24'h1;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while data pending");
	a_lock_out: assert property (lock_status |-> pll_out_enable)
		else $error("locked but output off");
	a_lock_narrow: assert property (lock_status |-> !loop_bw_wide)
		else $error("wide band while locked");
	a_reset_wide: assert property ($fell(rst) |-> loop_bw_wide)
		else $error("not wide after reset");
	a_loss_unlocks: assert property (idle_reg >= LOSS_CYCLES + 8
		|-> !lock_status) else $error("still locked after timeout");
	a_gap_holds: assert property (lock_status && idle_reg >= 8 &&
		idle_reg < LOSS_CYCLES - 8 |=> lock_status)
		else $error("lock lost inside timeout");
endmodule

bind cls_ctrl cls_ctrl_properties #(
	.SKIP_CYCLES(SKIP_CYCLES),
	.LOSS_CYCLES(LOSS_CYCLES)
) u_props (
	.clock, .rst, .reference_input_pin, .pll_out_enable, .lock_status,
	.loop_bw_wide, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

//--- tb/cls_ref_source.sv
// Jittery reference source and feedback clock for the supervisor
`timescale 1ns/1ps
module cls_ref_source (
	input wire logic clock,
	input wire logic rst,
	input wire logic enable,
	input wire logic glitch,
	input wire logic [15:0] period,
	output logic ref_out,
	output logic fb_out
);
	// ==========================================
	// Period counter, one cycle of jitter on alternate periods
	logic [15:0] cnt_reg; // Cycles into the current period
	logic jit_reg; // Lengthens every other period
	// Slow reference, windows scaled down alike
	wire logic [15:0] last = period - {15'h0, !jit_reg};
	// Glitch forces an early edge on command
	wire logic wrap = glitch || (enable && cnt_reg >= last);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg <= 16'h0;
			jit_reg <= 1'b0;
			fb_out <= 1'b0;
		end else begin
			fb_out <= ~fb_out;
			if (wrap) begin
				cnt_reg <= 16'h0;
				jit_reg <= ~jit_reg;
			end else if (enable) begin
				cnt_reg <= cnt_reg + 16'h1;
			end
		end
	end
	// Stopped source stands low
	assign ref_out = enable && (cnt_reg < 16'h4);
endmodule

//--- tb/tb_clkin_loss_skip_lock_ctrl.sv
// Self-checking bench for the reference loss and lock supervisor
`timescale 1ns/1ps
module tb_clkin_loss_skip_lock_ctrl;
	// ==========================================
	// Signals
	localparam int LIMIT = 50000; // Cycle ceiling
	localparam int PER = 40; // Reference period in cycles
	logic clock = 1'b0, rst = 1'b1, ref_en = 1'b1, glitch = 1'b0;
	logic watch = 1'b0; // Lock and output must stay up
	logic reference_input_pin, feedback_pin, pll_out_enable, lock_status;
	logic loop_bw_wide, irq;
	logic [1:0] ref_divider_sel, s_axi_bresp, s_axi_rresp;
	cls_pkg::cls_word_t synth_divide;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	int errors, num_checks, cycles, drops;
	always #4 clock = ~clock;
	cls_ctrl #(.SKIP_CYCLES(24'd200), .LOSS_CYCLES(24'd2000)) dut (
		.clock, .rst, .reference_input_pin, .feedback_pin, .ref_divider_sel,
		.synth_divide, .pll_out_enable, .lock_status, .loop_bw_wide, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready
	);
	cls_ref_source u_src (
		.clock, .rst, .enable(ref_en), .glitch, .period(16'(PER)),
		.ref_out(reference_input_pin), .fb_out(feedback_pin)
	);
	// ==========================================
	// Helpers
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Drop counter while watched, and hang cut-off
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (watch && {lock_status, pll_out_enable} !== 2'b11) drops++;
		if (cycles == LIMIT) begin
			errors++;
			end_of_test();
		end
	end
	// Bus write; ready for the answer only once it shows
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b1;
		@(posedge clock);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
	endtask
	// Bus read; compares masked data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [31:0] m, input logic [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b1;
		@(posedge clock);
		chk(s_axi_rdata & m, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		s_axi_rready <= 1'b0;
	endtask
	task automatic wait_lock();
		int n;
		n = 0;
		while (lock_status !== 1'b1 && n < 8000) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, lock_status}, 32'h1);
	endtask
	// Reference stops for n cycles, watched throughout
	task automatic gap(input int n, input logic keep);
		@(posedge clock);
		drops = 0;
		ref_en <= 1'b0;
		watch <= 1'b1;
		repeat (n) @(posedge clock);
		ref_en <= 1'b1;
		watch <= keep;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs();
		rd(8'h04, 32'h100, 32'hffffffff, 2'b00);
		rd(8'h14, 32'h100, 32'hffffffff, 2'b00);
		rd(8'h18, 32'h0, 32'hffffffff, 2'b10);
		wr(8'h08, 32'hff, 2'b10);
		for (int s = 0; s < 8; s++) begin
			wr(8'h00, {25'h0, 3'(s), 4'(s & 3)}, 2'b00);
			rd(8'h00, {25'h0, 3'(s), 4'(s & 3)}, 32'hffffffff, 2'b00);
			chk({30'h0, ref_divider_sel}, 32'(s & 3));
		end
		wr(8'h00, 32'h0, 2'b00);
		// No byte lanes enabled: the control word must not move
		s_axi_wstrb <= 4'h0;
		wr(8'h00, 32'h7f, 2'b00);
		rd(8'h00, 32'h0, 32'hffffffff, 2'b00);
		s_axi_wstrb <= 4'hf;
	endtask
	task automatic t_lock();
		repeat (50 * PER) @(posedge clock);
		chk({30'h0, lock_status, loop_bw_wide}, 32'h1);
		wait_lock();
		chk({30'h0, loop_bw_wide, pll_out_enable}, 32'h1);
		chk({31'h0, synth_divide > 32'h100}, 32'h1);
		rd(8'h08, 32'h13, 32'h3f, 2'b00);
		rd(8'h0c, 32'h1, 32'hf, 2'b00);
		chk({31'h0, irq}, 32'h0);
		wr(8'h10, 32'hf, 2'b00);
		chk({31'h0, irq}, 32'h1);
		wr(8'h0c, 32'h1, 2'b00);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_skip_on();
		wr(8'h00, 32'h4, 2'b00);
		gap(100, 1'b1);
		repeat (110 * PER) @(posedge clock);
		watch <= 1'b0;
		chk(drops, 0);
		// Reacquisition must be over before the next gap starts
		rd(8'h08, 32'h13, 32'h3f, 2'b00);
	endtask
	task automatic t_skip_off();
		wr(8'h00, 32'h0, 2'b00);
		gap(100, 1'b0);
		chk(drops, 0);
		repeat (2 * PER) @(posedge clock);
		chk({30'h0, lock_status, pll_out_enable}, 32'h0);
		wait_lock();
	endtask
	task automatic t_long_gap();
		wr(8'h00, 32'hc, 2'b00);
		gap(1000, 1'b0);
		chk(drops, 0);
		repeat (2 * PER) @(posedge clock);
		chk({30'h0, lock_status, pll_out_enable}, 32'h1);
		wait_lock();
	endtask
	task automatic t_glitch();
		wr(8'h00, 32'h0, 2'b00);
		wr(8'h0c, 32'hf, 2'b00);
		@(posedge reference_input_pin);
		repeat (15) @(posedge clock);
		glitch <= 1'b1;
		@(posedge clock);
		glitch <= 1'b0;
		repeat (10) @(posedge clock);
		chk({30'h0, lock_status, irq}, 32'h1);
		rd(8'h0c, 32'h8, 32'h8, 2'b00);
		wait_lock();
	endtask
	task automatic t_loss();
		wr(8'h0c, 32'hf, 2'b00);
		@(posedge clock);
		ref_en <= 1'b0;
		repeat (1900) @(posedge clock);
		chk({30'h0, lock_status, pll_out_enable}, 32'h3);
		repeat (300) @(posedge clock);
		chk({30'h0, lock_status, pll_out_enable}, 32'h0);
		rd(8'h0c, 32'h4, 32'h4, 2'b00);
		ref_en <= 1'b1;
		repeat (50 * PER) @(posedge clock);
		chk({31'h0, lock_status}, 32'h0);
		wait_lock();
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_lock();
		t_skip_on();
		t_skip_off();
		t_long_gap();
		t_glitch();
		t_loss();
		end_of_test();
	end
endmodule
